//--- logic/adcr_defs.svh
// Constants of the serial readout block: widths, codes, pulse counts and times
`ifndef ADCR_DEFS_SVH
`define ADCR_DEFS_SVH

// Widths
`define ADCR_WORD_W 20
`define ADCR_CNT_W 5
`define ADCR_TMR_W 24
`define ADCR_HI_W 8

// Output codes
`define ADCR_POS_FS 20'h7_FFFF
`define ADCR_NEG_FS 20'h8_0000

// Serial clock pulse counts
`define ADCR_LAST_BIT 5'h14
`define ADCR_LAST_ONE 5'h18
`define ADCR_CAL_PULSE 5'h1A
`define ADCR_CNT_MAX 5'h1F

// Times in ns
`define ADCR_CLK_NS 100
`define ADCR_CONV_FAST_NS 12_500_000
`define ADCR_CONV_SLOW_NS 100_000_000
`define ADCR_UPDATE_NS 39_000
`define ADCR_CAL_FAST_NS 101_280_000
`define ADCR_CAL_SLOW_NS 801_020_000
`define ADCR_STBY_NS 20_000
`define ADCR_WAKE_FAST_NS 52_510_000
`define ADCR_WAKE_SLOW_NS 401_800_000

`endif

//--- logic/adcr_pkg.sv
// Types shared by the serial readout block
`include "adcr_defs.svh"
package adcr_pkg;

    typedef enum logic [3:0] {
        ADCR_ST_CONV = 4'h1,
        ADCR_ST_UPD = 4'h2,
        ADCR_ST_SETTLE = 4'h4,
        ADCR_ST_STBY = 4'h8
    } adcr_st_t;

    typedef logic [`ADCR_WORD_W-1:0] adcr_word_t;

    typedef struct packed {
        logic sclk;
        logic rate;
    } adcr_pin_t;

    typedef struct packed {
        adcr_st_t st;
        logic [`ADCR_TMR_W-1:0] tmr;
        adcr_word_t word;
        adcr_word_t shreg;
        logic [`ADCR_CNT_W-1:0] cnt;
        logic [`ADCR_HI_W-1:0] hi;
        logic dout;
        logic cal;
        logic armed;
        logic sclk_prev;
    } adcr_state_t;

endpackage : adcr_pkg

//--- logic/adcr_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module adcr_sync #(
    parameter int N = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Levels
    input wire logic [N-1:0] d,
    output logic [N-1:0] q
);
    import adcr_pkg::*;

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
    } adcr_sync_state_t;

    adcr_sync_state_t s, n;

    always_comb begin
        n.s1 = d;
        n.s2 = s.s1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign q = s.s2;
endmodule : adcr_sync
`default_nettype wire

//--- logic/adcr_fifo.sv
// Flip-flop FIFO between the converter core and the readout
`timescale 1ns/1ps
`default_nettype none
module adcr_fifo #(
    parameter int W = 20,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    import adcr_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } adcr_fifo_state_t;

    adcr_fifo_state_t s, n;
    logic push;
    logic pop;

    assign in_ready = (s.cnt != CW'(DEPTH));
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rd];

    always_comb begin
        n = s;
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        if (push) begin
            n.mem[s.wr] = in_data;
            n.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
        end
        if (pop) begin
            n.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
        end
        n.cnt = s.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule : adcr_fifo
`default_nettype wire

//--- logic/adcr_readout.sv
// Serial readout, calibration request and standby control of the converter
//
// Contract
// - Results are 20-bit two's complement words.
// - Clip to 7FFFFh and 80000h beyond full scale.
// - Zero input gives 00000h, one step 00001h.
// - Twenty serial clocks shift result out MSB-first.
// - Pulses 21 to 24 present ones.
// - Ready low, then MSB on first rising edge.
// - Each later rising edge advances one bit.
// - Extra pulse forces high until next result.
// - New result replaces old, read or not.
// - After exactly twenty pulses, last bit holds.
// - Period 12.5 ms fast, 100 ms slow.
// - Falling edge of pulse 26 starts calibration.
// - Calibration disconnects inputs; host keeps clock quiet.
// - Calibration end drives ready low, settled data.
// - Calibration ready 101.28 ms fast, 801.02 slow.
// - Clock held high 20 us enters standby.
// - Standby powers analog down, output held high.
// - Clock low wakes; first result is valid.
// - Wake ready 52.51 ms fast, 401.8 slow.
// - Rate select low 10 SPS, high 80 SPS.
`timescale 1ns/1ps
`default_nettype none
`include "adcr_defs.svh"
module adcr_readout #(
    parameter int RAW_W = 24,
    parameter int FIFO_DEPTH = 4,
    parameter int CONV_FAST_CYC = `ADCR_CONV_FAST_NS / `ADCR_CLK_NS,
    parameter int CONV_SLOW_CYC = `ADCR_CONV_SLOW_NS / `ADCR_CLK_NS,
    parameter int CAL_FAST_CYC = (`ADCR_CAL_FAST_NS + `ADCR_CLK_NS - 1) / `ADCR_CLK_NS,
    parameter int CAL_SLOW_CYC = (`ADCR_CAL_SLOW_NS + `ADCR_CLK_NS - 1) / `ADCR_CLK_NS,
    parameter int WAKE_FAST_CYC = (`ADCR_WAKE_FAST_NS + `ADCR_CLK_NS - 1) / `ADCR_CLK_NS,
    parameter int WAKE_SLOW_CYC = (`ADCR_WAKE_SLOW_NS + `ADCR_CLK_NS - 1) / `ADCR_CLK_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Host pins
    input wire logic serial_clk,
    input wire logic rate_select,
    output logic ready_data_out,
    // Converter core results
    input wire logic core_valid,
    input wire logic signed [RAW_W-1:0] core_raw,
    output logic core_ready,
    // Analog control
    output logic analog_power_on,
    output logic inputs_disconnected,
    output logic standby_active
);
    import adcr_pkg::*;

    localparam int W = `ADCR_WORD_W;
    localparam int TW = `ADCR_TMR_W;
    localparam int HW = `ADCR_HI_W;
    localparam int UPD_CYC = (`ADCR_UPDATE_NS + `ADCR_CLK_NS - 1) / `ADCR_CLK_NS;
    localparam int STBY_CYC = (`ADCR_STBY_NS + `ADCR_CLK_NS - 1) / `ADCR_CLK_NS;
    localparam adcr_state_t RST = '{st: ADCR_ST_CONV, dout: 1'b1, default: '0};

    adcr_pin_t pin_raw;
    adcr_pin_t pin_s;
    adcr_state_t s, n;
    adcr_word_t fill_word;
    adcr_word_t f_data;
    logic f_valid;
    logic pop;
    logic load;
    logic rise;
    logic fall;
    logic sclk_s;
    logic [TW-1:0] conv_cyc;
    logic [TW-1:0] cal_cyc;
    logic [TW-1:0] wake_cyc;

    // Clip the core's wider result into the output word
    function automatic adcr_word_t sat_code(input logic signed [RAW_W-1:0] raw);
        logic signed [RAW_W-1:0] hi_lim;
        logic signed [RAW_W-1:0] lo_lim;
        hi_lim = {{(RAW_W - W){1'b0}}, `ADCR_POS_FS};
        lo_lim = {{(RAW_W - W){1'b1}}, `ADCR_NEG_FS};
        if (raw >= hi_lim) begin
            return `ADCR_POS_FS;
        end else if (raw <= lo_lim) begin
            return `ADCR_NEG_FS;
        end
        return raw[W-1:0];
    endfunction : sat_code

    assign pin_raw = '{sclk: serial_clk, rate: rate_select};

    adcr_sync #(
        .N($bits(adcr_pin_t))
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .d(pin_raw),
        .q(pin_s)
    );

    assign fill_word = sat_code(core_raw);

    // Back-pressure: the core stalls while the FIFO is full; each result load drains one word if the FIFO holds any
    adcr_fifo #(
        .W(W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(core_valid),
        .in_data(fill_word),
        .in_ready(core_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(pop)
    );

    assign sclk_s = pin_s.sclk;
    assign rise = sclk_s & ~s.sclk_prev;
    assign fall = ~sclk_s & s.sclk_prev;

    // Timer reloads follow the rate pin; low rate is 10 SPS, high 80 SPS
    always_comb begin
        if (pin_s.rate) begin
            conv_cyc = TW'(CONV_FAST_CYC - UPD_CYC - 1);
            cal_cyc = TW'(CAL_FAST_CYC - 1);
            wake_cyc = TW'(WAKE_FAST_CYC - 1);
        end else begin
            conv_cyc = TW'(CONV_SLOW_CYC - UPD_CYC - 1);
            cal_cyc = TW'(CAL_SLOW_CYC - 1);
            wake_cyc = TW'(WAKE_SLOW_CYC - 1);
        end
    end

    always_comb begin
        n = s;
        load = 1'b0;
        n.sclk_prev = sclk_s;
        if (s.tmr != '0) begin
            n.tmr = s.tmr - 1'b1;
        end
        n.hi = '0;
        case (s.st)
            ADCR_ST_CONV: begin
                if (sclk_s && s.hi != '1) begin
                    n.hi = s.hi + 1'b1;
                end else if (sclk_s) begin
                    n.hi = s.hi;
                end
                if (rise && s.cnt != `ADCR_CNT_MAX) begin
                    n.cnt = s.cnt + 1'b1;
                end
                if (rise && s.cnt < `ADCR_LAST_BIT) begin
                    n.dout = s.shreg[W-1];
                    n.shreg = {s.shreg[W-2:0], 1'b0};
                end else if (rise) begin
                    n.dout = 1'b1;
                end
                // Host may still be mid-readout; stalling it is its concern
                if (fall && s.cnt == `ADCR_CAL_PULSE) begin
                    n.st = ADCR_ST_SETTLE;
                    n.cal = 1'b1;
                    n.tmr = cal_cyc;
                    n.dout = 1'b1;
                    n.armed = 1'b0;
                end else if (s.armed && sclk_s && s.hi >= HW'(STBY_CYC)) begin
                    n.st = ADCR_ST_STBY;
                    n.dout = 1'b1;
                    n.armed = 1'b0;
                end else if (s.tmr == '0) begin
                    n.st = ADCR_ST_UPD;
                    n.tmr = TW'(UPD_CYC - 1);
                    n.dout = 1'b1;
                end
            end
            ADCR_ST_UPD: begin
                n.dout = 1'b1;
                load = (s.tmr == '0);
            end
            ADCR_ST_SETTLE: begin
                n.dout = 1'b1;
                load = (s.tmr == '0);
            end
            ADCR_ST_STBY: begin
                n.dout = 1'b1;
                if (!sclk_s) begin
                    n.st = ADCR_ST_SETTLE;
                    n.cal = 1'b0;
                    n.tmr = wake_cyc;
                end
            end
            default: begin
                n = RST;
            end
        endcase
        if (load) begin
            // An empty FIFO repeats the last word rather than stall the pin
            n.st = ADCR_ST_CONV;
            n.word = f_valid ? f_data : s.word;
            n.shreg = f_valid ? f_data : s.word;
            n.dout = 1'b0;
            n.cnt = '0;
            n.cal = 1'b0;
            n.armed = 1'b1;
            n.tmr = conv_cyc;
        end
    end

    assign pop = load & f_valid;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= RST;
        end else begin
            s <= n;
        end
    end

    assign ready_data_out = s.dout;
    assign standby_active = (s.st == ADCR_ST_STBY);
    assign analog_power_on = (s.st != ADCR_ST_STBY);
    assign inputs_disconnected = s.cal;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_shift_bit;
        s.st == ADCR_ST_CONV && n.st == ADCR_ST_CONV && rise && s.cnt < `ADCR_LAST_BIT;
    endsequence

    sequence s_tail_pulse;
        s.st == ADCR_ST_CONV && n.st == ADCR_ST_CONV && rise && s.cnt >= `ADCR_LAST_BIT;
    endsequence

    sequence s_cal_request;
        s.st == ADCR_ST_CONV && fall && s.cnt == `ADCR_CAL_PULSE;
    endsequence

    sequence s_upd_enter;
        s.st == ADCR_ST_CONV && n.st == ADCR_ST_UPD;
    endsequence

    sequence s_count_rise;
        s.st == ADCR_ST_CONV && rise && s.cnt != `ADCR_CNT_MAX;
    endsequence

    a_ready_low_load:
    assert property (load |=> !ready_data_out && s.cnt == '0 && s.st == ADCR_ST_CONV)
        else $error("ready not low with cleared count after new result");

    a_msb_shift_out:
    assert property (s_shift_bit |=> ready_data_out == $past(s.shreg[W-1]))
        else $error("output bit not taken from top of shift register");

    a_tail_ones_out:
    assert property (s_tail_pulse |=> ready_data_out ##1 (ready_data_out || s.st != ADCR_ST_UPD))
        else $error("pulses past twenty did not present a one");

    a_last_bit_hold:
    assert property (s.st == ADCR_ST_CONV && n.st == ADCR_ST_CONV && !rise
                     |=> $stable(ready_data_out))
        else $error("output changed without a rising serial clock");

    a_clip_positive:
    assert property (core_valid && core_raw >= $signed({{(RAW_W - W){1'b0}}, `ADCR_POS_FS})
                     |-> fill_word == `ADCR_POS_FS)
        else $error("positive overrange not clipped");

    a_clip_negative:
    assert property (core_valid && core_raw <= $signed({{(RAW_W - W){1'b1}}, `ADCR_NEG_FS})
                     |-> fill_word == `ADCR_NEG_FS)
        else $error("negative overrange not clipped");

    a_code_passes:
    assert property (core_valid && core_raw < $signed({{(RAW_W - W){1'b0}}, `ADCR_POS_FS})
                     && core_raw > $signed({{(RAW_W - W){1'b1}}, `ADCR_NEG_FS})
                     |-> fill_word == core_raw[W-1:0])
        else $error("in-range code altered");

    a_result_replaced:
    assert property (load && f_valid |=> s.shreg == $past(f_data) && s.word == $past(f_data))
        else $error("new result did not replace the stored one");

    a_update_high:
    assert property (s_upd_enter |=> ready_data_out [*8])
        else $error("output not high through update interval");

    a_period_reload:
    assert property (load |=> s.tmr == $past(conv_cyc))
        else $error("conversion timer reload wrong");

    a_cal_start:
    assert property (s_cal_request |=> s.st == ADCR_ST_SETTLE && inputs_disconnected
                     && ready_data_out && s.tmr == $past(cal_cyc))
        else $error("pulse 26 falling edge did not start calibration");

    a_cal_done:
    assert property (s.st == ADCR_ST_SETTLE && s.tmr == '0
                     |=> !ready_data_out && !inputs_disconnected)
        else $error("calibration end did not signal ready");

    a_standby_entry:
    assert property (s.st == ADCR_ST_CONV && n.st == ADCR_ST_STBY
                     |-> s.hi >= HW'(STBY_CYC) && s.armed && sclk_s)
        else $error("standby entered without hold time");

    a_standby_state:
    assert property (standby_active |-> ready_data_out && !analog_power_on)
        else $error("standby did not hold output high and analog off");

    a_wake_start:
    assert property (standby_active && !sclk_s |=> s.st == ADCR_ST_SETTLE
                     && !inputs_disconnected && s.tmr == $past(wake_cyc))
        else $error("wake-up did not start settling timer");

    a_count_step:
    assert property (s_count_rise |=> s.cnt == $past(s.cnt) + 1'b1)
        else $error("rising serial clock not counted");

    a_count_frozen:
    assert property (s.st != ADCR_ST_CONV && !load |=> $stable(s.cnt))
        else $error("edge count moved outside conversion");

    a_inputs_cal:
    assert property (inputs_disconnected |-> s.st == ADCR_ST_SETTLE)
        else $error("inputs disconnected outside calibration");

    a_standby_hold:
    assert property (standby_active && sclk_s |=> standby_active && ready_data_out)
        else $error("standby left while serial clock high");

    a_settle_high:
    assert property (s.st == ADCR_ST_SETTLE && s.tmr != '0
                     |=> s.st == ADCR_ST_SETTLE && ready_data_out)
        else $error("result signalled before settling timer ran out");

endmodule : adcr_readout
`default_nettype wire

//--- tb/adcr_host.sv
// Host model: drives the serial clock and samples the ready/data pin
`timescale 1ns/1ps
`default_nettype none
module adcr_host (
    // Clock
    input wire logic clk,
    // Link pins
    output logic serial_clk,
    input wire logic ready_data_out
);
    initial serial_clk = 1'b0;

    // Pulses 400 ns high in an 800 ns period; each bit sampled just before the next rise, where it must stand
    task automatic shift(input int n, output logic [31:0] seen);
        seen = '0;
        for (int i = 0; i < n; i++) begin
            serial_clk = 1'b1;
            repeat (4) @(posedge clk);
            #1 serial_clk = 1'b0;
            repeat (4) @(posedge clk);
            #1 seen = {seen[30:0], ready_data_out};
        end
    endtask : shift

    // Held high right after a load requests standby; low again wakes
    task automatic set_level(input logic lvl);
        serial_clk = lvl;
    endtask : set_level
endmodule : adcr_host
`default_nettype wire

//--- tb/adcr_readout_tb.sv
// Self-checking bench of the serial readout block
`timescale 1ns/1ps
`default_nettype none
module adcr_readout_tb;
    import adcr_pkg::*;
    localparam int CONV = 1000;
    localparam int CAL = 600;
    localparam int WAKE = 500;
    localparam logic [23:0] RAW [6] = '{24'h12_3456, 24'hE0_0000, 24'h00_0005,
        24'h00_0000, 24'hFF_FFFF, 24'h00_0001};
    localparam logic [19:0] WORD [6] = '{20'h7_FFFF, 20'h8_0000, 20'h0_0005,
        20'h0_0000, 20'hF_FFFF, 20'h0_0001};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic rate_select = 1'b1;
    logic core_valid = 1'b0;
    logic signed [23:0] core_raw = '0;
    logic serial_clk, ready_data_out, core_ready;
    logic analog_power_on, inputs_disconnected, standby_active;
    logic [31:0] seen;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int last_fall = 0;

    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    adcr_readout #(.CONV_FAST_CYC(CONV), .CONV_SLOW_CYC(2 * CONV), .CAL_FAST_CYC(CAL),
        .CAL_SLOW_CYC(CAL), .WAKE_FAST_CYC(WAKE), .WAKE_SLOW_CYC(WAKE)) dut_u (
        .clk(clk), .reset(reset), .serial_clk(serial_clk), .rate_select(rate_select),
        .ready_data_out(ready_data_out), .core_valid(core_valid), .core_raw(core_raw),
        .core_ready(core_ready), .analog_power_on(analog_power_on),
        .inputs_disconnected(inputs_disconnected), .standby_active(standby_active));

    adcr_host host_u (.clk(clk), .serial_clk(serial_clk), .ready_data_out(ready_data_out));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic check_range(input string what, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            errors++;
            $display("mismatch %s expected %0d to %0d seen %0d", what, lo, hi, got);
        end
    endtask : check_range

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Pin high first, then the fall of a fresh result; gap is load to load
    task automatic wait_load(output int gap);
        int n;
        n = 0;
        while (ready_data_out !== 1'b1 && n < 5000) begin
            tick(1);
            n++;
        end
        while (ready_data_out !== 1'b0 && n < 5000) begin
            tick(1);
            n++;
        end
        if (n >= 5000) check("load wait", 32'h0000_0000, 32'h0000_0001);
        gap = cyc - last_fall;
        last_fall = cyc;
    endtask : wait_load

    // Cycles from now until the pin falls
    task automatic time_to_low(output int n);
        n = 0;
        while (ready_data_out !== 1'b0 && n < 3000) begin
            tick(1);
            n++;
        end
    endtask : time_to_low

    // Fills the buffer to its depth, then adds one word each time a load drains one
    task automatic feed();
        for (int i = 0; i < 6; i++) begin
            core_valid = 1'b1;
            core_raw = RAW[i];
            if (i == 4) check("core_ready full", 1'b0, core_ready);
            while (core_ready !== 1'b1) tick(1);
            tick(1);
        end
        core_valid = 1'b0;
    endtask : feed

    task automatic read_codes();
        int gap;
        wait_load(gap);
        host_u.shift(24, seen);
        check("word 1", {WORD[0], 4'hF}, seen[23:0]);
        tick(300);
        check("pin after read", 1'b1, ready_data_out);
        wait_load(gap);
        check("period fast", CONV, gap);
        host_u.shift(20, seen);
        check("word 2", WORD[1], seen[19:0]);
        tick(100);
        check("last bit held", 1'b0, ready_data_out);
        // Third result is left unread and must be overwritten
        wait_load(gap);
        wait_load(gap);
        host_u.shift(24, seen);
        check("word 4", {WORD[3], 4'hF}, seen[23:0]);
    endtask : read_codes

    task automatic calibrate();
        int gap;
        int n;
        wait_load(gap);
        host_u.shift(26, seen);
        check("word 5", {WORD[4], 6'h3F}, seen[25:0]);
        tick(4);
        check("inputs off", 1'b1, inputs_disconnected);
        check("pin during cal", 1'b1, ready_data_out);
        time_to_low(n);
        check_range("cal ready", CAL, CAL + 10, n + 8);
        host_u.shift(24, seen);
        check("word after cal", {WORD[5], 4'hF}, seen[23:0]);
    endtask : calibrate

    task automatic standby();
        int gap;
        int n;
        wait_load(gap);
        host_u.set_level(1'b1);
        tick(190);
        check("not yet standby", 1'b0, standby_active);
        tick(25);
        check("standby", 1'b1, standby_active);
        check("analog off", 1'b0, analog_power_on);
        tick(1500);
        check("pin in standby", 1'b1, ready_data_out);
        host_u.set_level(1'b0);
        time_to_low(n);
        check_range("wake ready", WAKE, WAKE + 10, n);
        check("analog on", 1'b1, analog_power_on);
        // Buffer drained: the last word repeats
        host_u.shift(24, seen);
        check("word after wake", {WORD[5], 4'hF}, seen[23:0]);
    endtask : standby

    task automatic rate_slow();
        int gap;
        rate_select = 1'b0;
        wait_load(gap);
        wait_load(gap);
        wait_load(gap);
        check("period slow", 2 * CONV, gap);
    endtask : rate_slow

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        fork
            feed();
            begin
                read_codes();
                calibrate();
                standby();
                rate_slow();
            end
        join
        print_verdict();
    end

    // Whole run needs about 13500 cycles
    initial begin
        #(60000 * 100);
        errors++;
        print_verdict();
    end
endmodule : adcr_readout_tb
`default_nettype wire
